/* File: design/cmf_accept_filter.sv */
`timescale 1ns/10ps
module cmf_accept_filter (
    // Mailbox setup
    input wire logic [cmf_pkg::ID_W-1:0] mbx_id_i,
    input wire logic mbx_ext_i,
    input wire logic [cmf_pkg::ID_W-1:0] local_accept_mask_i,
    input wire logic mask_format_select_i,
    // Incoming frame
    input wire logic [cmf_pkg::ID_W-1:0] rx_id_i,
    input wire logic rx_ext_i,
    // Result
    output logic match_o
);
    import cmf_pkg::*;

    logic format_ok;
    logic [ID_W-1:0] care_bits;

    assign format_ok = mask_format_select_i | (rx_ext_i == mbx_ext_i);
    // Standard frames only look at the upper eleven identifier bits
    assign care_bits = ~local_accept_mask_i &
        (rx_ext_i ? {ID_W{1'b1}} : STD_ID_BITS);
    assign match_o = format_ok && (((rx_id_i ^ mbx_id_i) & care_bits) == '0);
endmodule

/* File: design/cmf_flag_vec.sv */
`timescale 1ns/10ps
// Hardware-set flags with clear request; a set in the same cycle wins
module cmf_flag_vec #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Flag control
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] flag_reg;
    logic [W-1:0] flag_next;

    assign flag_next = (flag_reg & ~clr_i) | set_i;
    assign q_o = flag_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end
endmodule

/* File: design/cmf_mailbox_ctrl.sv */
`timescale 1ns/10ps
module cmf_mailbox_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [cmf_pkg::ADDR_W-1:0] addr_i,
    input wire logic [cmf_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_stb_i,
    input wire logic rd_stb_i,
    output logic [cmf_pkg::DATA_W-1:0] rdata_o,
    // Receive side of the protocol engine
    input wire logic rx_valid_i,
    input wire logic [cmf_pkg::ID_W-1:0] rx_id_i,
    input wire logic rx_ext_i,
    input wire logic rx_remote_i,
    output logic rx_store_o,
    output logic [1:0] rx_store_mbx_o,
    // Transmit side of the protocol engine
    output logic [3:0] tx_request_o,
    output logic [3:0] tx_cancel_o,
    input wire logic tx_busy_i,
    input wire logic [2:0] tx_mbx_i,
    input wire logic tx_done_i,
    input wire logic tx_abort_i,
    input wire logic tx_error_i,
    // Interrupt lines toward the system
    output logic mailbox_irq_o,
    output logic error_irq_o
);
    import cmf_pkg::*;

    // Configuration state
    logic [1:0] mailbox_direction_bit_reg;
    logic [5:0] mailbox_on_bit_reg;
    logic [15:0] mask_hi_reg [0:1];
    logic [15:0] mask_lo_reg [0:1];
    logic [3:0] overwrite_protect_reg;
    logic [15:0] interrupt_mask_reg;
    logic [15:0] id_hi_reg [0:NUM_MBX-1];
    logic [15:0] id_lo_reg [0:NUM_MBX-1];
    // Transmit and receive status
    logic [3:0] tx_request_reg;
    logic [3:0] tx_request_next;
    logic [3:0] tx_cancel_request_reg;
    logic [3:0] tx_cancel_request_next;
    logic [3:0] remote_pending_reg;
    logic [3:0] remote_pending_next;
    logic [3:0] tx_acknowledge;
    logic [3:0] abort_acknowledge;
    logic [3:0] receive_pending;
    logic [3:0] receive_lost;
    logic [2:0] status_flags;
    // Outputs
    logic [DATA_W-1:0] rdata_reg;
    logic rx_store_reg;
    logic [1:0] rx_store_mbx_reg;
    logic mailbox_irq_reg;
    logic error_irq_reg;

    // Register decode
    wire wr_mailbox_dir_enable_reg = wr_stb_i && (addr_i == OFF_MAILBOX_DIR_ENABLE_REG);
    wire wr_tcr = wr_stb_i && (addr_i == OFF_TCR);
    wire wr_rcr = wr_stb_i && (addr_i == OFF_RCR);
    wire wr_status = wr_stb_i && (addr_i == OFF_STATUS);
    wire wr_int_mask = wr_stb_i && (addr_i == OFF_INT_MASK);
    wire id_space = (addr_i[15:4] == OFF_ID_BASE[15:4]) && (addr_i[3:0] < 4'hC);
    wire [2:0] id_mbx = addr_i[3:1];
    wire id_is_low = addr_i[0];

    // Mailbox write locks
    wire [5:0] tx_locked = {tx_request_reg | tx_cancel_request_reg, 2'b00};
    wire id_wr_try = wr_stb_i && id_space;
    wire id_wr_ok = id_wr_try && !mailbox_on_bit_reg[id_mbx] && !tx_locked[id_mbx];
    wire write_denied_set = id_wr_try && tx_locked[id_mbx];

    // Acceptance filtering for the four mailboxes that can receive
    wire [3:0] is_rx_mbx = {mailbox_direction_bit_reg, 2'b11};
    logic [3:0] id_match;
    logic [3:0] eligible;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filter
            localparam int MSEL = (gi >= 2) ? 1 : 0;
            cmf_accept_filter u_filter (
                .mbx_id_i({id_hi_reg[gi][12:0], id_lo_reg[gi]}),
                .mbx_ext_i(id_hi_reg[gi][ID_EXT_BIT]),
                .local_accept_mask_i({mask_hi_reg[MSEL][12:0], mask_lo_reg[MSEL]}),
                .mask_format_select_i(mask_hi_reg[MSEL][MASK_SEL_BIT]),
                .rx_id_i(rx_id_i),
                .rx_ext_i(rx_ext_i),
                .match_o(id_match[gi])
            );
            // A protected unread mailbox steps aside for the next one
            assign eligible[gi] = rx_valid_i && mailbox_on_bit_reg[gi] && id_match[gi] &&
                (is_rx_mbx[gi] ? (!receive_pending[gi] || !overwrite_protect_reg[gi])
                               : rx_remote_i);
        end
    endgenerate

    // Highest mailbox first
    wire [3:0] rx_sel = {eligible[3],
                         eligible[2] & ~eligible[3],
                         eligible[1] & ~|eligible[3:2],
                         eligible[0] & ~|eligible[3:1]};
    wire [3:0] rx_store = rx_sel & is_rx_mbx;
    wire [3:0] remote_answer = rx_sel & ~is_rx_mbx;
    wire [3:0] remote_seen = rx_sel & {4{rx_remote_i}};
    wire [3:0] lost_set = rx_store & receive_pending & ~overwrite_protect_reg;

    // Transmit events per mailbox 5..2, index 0 is mailbox two
    logic [3:0] tx_current;
    logic [3:0] tx_ok;
    logic [3:0] tx_abt;
    logic [3:0] tx_err;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_txev
            localparam logic [2:0] MBX = 3'(gi + 2);
            assign tx_current[gi] = tx_busy_i && (tx_mbx_i == MBX);
            assign tx_ok[gi] = tx_done_i && (tx_mbx_i == MBX);
            assign tx_abt[gi] = tx_abort_i && (tx_mbx_i == MBX);
            assign tx_err[gi] = tx_error_i && (tx_mbx_i == MBX);
        end
    endgenerate

    wire [3:0] withdraw = tx_cancel_request_reg & tx_request_reg & ~tx_current;
    wire [3:0] cancel_abort = tx_cancel_request_reg & tx_abt;
    wire [3:0] cancel_error = tx_cancel_request_reg & tx_err;
    wire [3:0] aa_set = withdraw | cancel_abort;
    // Lost arbitration or error without a cancel is simply retried
    wire [3:0] tx_req_clr = tx_ok | withdraw | cancel_abort | cancel_error;
    wire [3:0] tx_req_sw = wr_tcr ? wdata_i[7:4] : 4'h0;
    wire [3:0] tx_req_rmt = {2'b00, remote_answer[3:2]};
    // A cancel with no request to act on is never latched, so it cannot linger a cycle
    wire [3:0] cancel_sw = wr_tcr ? (wdata_i[3:0] & (tx_request_reg | wdata_i[7:4])) : 4'h0;
    wire [3:0] cancel_clr = withdraw | (tx_cancel_request_reg & ~tx_request_reg) |
                            (tx_cancel_request_reg & (tx_ok | tx_abt | tx_err));

    // Software set wins over the engine's clear
    assign tx_request_next = (tx_request_reg & ~tx_req_clr) | tx_req_sw | tx_req_rmt;
    assign tx_cancel_request_next = (tx_cancel_request_reg & ~cancel_clr) | cancel_sw;

    // Remote pending: software clear only while no request, clear wins
    wire [3:0] trs_by_mbx = {tx_request_reg[1:0], 2'b00};
    wire [3:0] rfp_sw_clr = wr_rcr ? (wdata_i[15:12] & ~trs_by_mbx) : 4'h0;
    wire [3:0] rfp_hw_clr = {tx_ok[1:0], 2'b00};
    assign remote_pending_next = (remote_pending_reg | remote_seen) &
                                 ~(rfp_sw_clr | rfp_hw_clr);

    // Write-one-to-clear sources
    wire [3:0] ta_clr = wr_tcr ? wdata_i[15:12] : 4'h0;
    wire [3:0] aa_clr = wr_tcr ? wdata_i[11:8] : 4'h0;
    wire [3:0] rmp_clr = wr_rcr ? wdata_i[7:4] : 4'h0;
    wire [2:0] st_clr = wr_status ? wdata_i[2:0] : 3'h0;
    wire [2:0] st_set;
    assign st_set[ST_WD_BIT] = write_denied_set;
    assign st_set[ST_ABORT_BIT] = |aa_set;
    assign st_set[ST_ERR_BIT] = |cancel_error;

    cmf_flag_vec #(.W(4)) u_tx_ack (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(tx_ok),
        .clr_i(ta_clr),
        .q_o(tx_acknowledge)
    );

    cmf_flag_vec #(.W(4)) u_abort_ack (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(aa_set),
        .clr_i(aa_clr),
        .q_o(abort_acknowledge)
    );

    cmf_flag_vec #(.W(4)) u_rx_pending (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(rx_store),
        .clr_i(rmp_clr),
        .q_o(receive_pending)
    );

    cmf_flag_vec #(.W(4)) u_rx_lost (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(lost_set),
        .clr_i(rmp_clr),
        .q_o(receive_lost)
    );

    cmf_flag_vec #(.W(3)) u_status (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(st_set),
        .clr_i(st_clr),
        .q_o(status_flags)
    );

    // Mailbox flags: receive pending for 0-3, transmit ack for 2-5
    wire [5:0] mbx_raw = {tx_acknowledge[3:2],
                          tx_acknowledge[1:0] | receive_pending[3:2],
                          receive_pending[1:0]};
    wire [5:0] mailbox_int_flag = mbx_raw & interrupt_mask_reg[5:0];
    wire error_irq_next =
        (status_flags[ST_ABORT_BIT] && interrupt_mask_reg[IM_ABORT_BIT]) ||
        (status_flags[ST_WD_BIT] && interrupt_mask_reg[IM_WD_BIT]) ||
        (status_flags[ST_ERR_BIT] && interrupt_mask_reg[IM_ERR_BIT]);

    // Read selection
    wire [15:0] mailbox_dir_enable_reg_val = {8'h00, mailbox_direction_bit_reg, mailbox_on_bit_reg};
    wire [15:0] tcr_val = {tx_acknowledge, abort_acknowledge,
                           tx_request_reg, tx_cancel_request_reg};
    wire [15:0] rcr_val = {remote_pending_reg, receive_lost,
                           receive_pending, overwrite_protect_reg};
    wire [15:0] status_val = {2'b00, mailbox_int_flag, 5'h00, status_flags};
    wire [15:0] id_val = id_is_low ? id_lo_reg[id_mbx] : id_hi_reg[id_mbx];
    wire [15:0] rd_val =
        (addr_i == OFF_MAILBOX_DIR_ENABLE_REG) ? mailbox_dir_enable_reg_val :
        (addr_i == OFF_TCR) ? tcr_val :
        (addr_i == OFF_RCR) ? rcr_val :
        (addr_i == OFF_MASK0_HI) ? mask_hi_reg[0] :
        (addr_i == OFF_MASK0_LO) ? mask_lo_reg[0] :
        (addr_i == OFF_MASK1_HI) ? mask_hi_reg[1] :
        (addr_i == OFF_MASK1_LO) ? mask_lo_reg[1] :
        (addr_i == OFF_STATUS) ? status_val :
        (addr_i == OFF_INT_MASK) ? interrupt_mask_reg :
        id_space ? id_val : 16'h0000;

    // Reserved bits of the mask high word are dropped on write
    wire [15:0] mask_hi_wr = {wdata_i[MASK_SEL_BIT], 2'b00, wdata_i[12:0]};

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mailbox_direction_bit_reg <= RST_MAILBOX_DIR_ENABLE_REG[7:6];
            mailbox_on_bit_reg <= RST_MAILBOX_DIR_ENABLE_REG[5:0];
            overwrite_protect_reg <= 4'h0;
            interrupt_mask_reg <= RST_INT_MASK;
        end else begin
            if (wr_mailbox_dir_enable_reg) begin
                mailbox_direction_bit_reg <= wdata_i[7:6];
                mailbox_on_bit_reg <= wdata_i[5:0];
            end
            if (wr_rcr) begin
                overwrite_protect_reg <= wdata_i[3:0];
            end
            if (wr_int_mask) begin
                interrupt_mask_reg <= {5'h00, wdata_i[10:8], 2'b00, wdata_i[5:0]};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int m = 0; m < 2; m++) begin
                mask_hi_reg[m] <= RST_MASK_HI;
                mask_lo_reg[m] <= RST_MASK_LO;
            end
        end else begin
            for (int m = 0; m < 2; m++) begin
                if (wr_stb_i && addr_i == (m == 0 ? OFF_MASK0_HI : OFF_MASK1_HI)) begin
                    mask_hi_reg[m] <= mask_hi_wr;
                end
                if (wr_stb_i && addr_i == (m == 0 ? OFF_MASK0_LO : OFF_MASK1_LO)) begin
                    mask_lo_reg[m] <= wdata_i;
                end
            end
        end
    end

    // Identifier words: written by software when unlocked, or by a stored frame
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int m = 0; m < NUM_MBX; m++) begin
                id_hi_reg[m] <= 16'h0000;
                id_lo_reg[m] <= 16'h0000;
            end
        end else begin
            for (int m = 0; m < NUM_MBX; m++) begin
                if (m < 4 && rx_store[m % 4]) begin
                    id_hi_reg[m] <= {rx_ext_i, 2'b00, rx_id_i[28:16]};
                    id_lo_reg[m] <= rx_id_i[15:0];
                end else if (id_wr_ok && id_mbx == 3'(m)) begin
                    if (id_is_low) begin
                        id_lo_reg[m] <= wdata_i;
                    end else begin
                        id_hi_reg[m] <= {wdata_i[ID_EXT_BIT], 2'b00, wdata_i[12:0]};
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_request_reg <= 4'h0;
            tx_cancel_request_reg <= 4'h0;
            remote_pending_reg <= 4'h0;
        end else begin
            tx_request_reg <= tx_request_next;
            tx_cancel_request_reg <= tx_cancel_request_next;
            remote_pending_reg <= remote_pending_next;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 16'h0000;
            rx_store_reg <= 1'b0;
            rx_store_mbx_reg <= 2'b00;
            mailbox_irq_reg <= 1'b0;
            error_irq_reg <= 1'b0;
        end else begin
            // Read data stands only in the cycle after the strobe
            rdata_reg <= rd_stb_i ? rd_val : 16'h0000;
            rx_store_reg <= |rx_store;
            rx_store_mbx_reg <= {rx_store[3] | rx_store[2], rx_store[3] | rx_store[1]};
            mailbox_irq_reg <= |mailbox_int_flag;
            error_irq_reg <= error_irq_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign rx_store_o = rx_store_reg;
    assign rx_store_mbx_o = rx_store_mbx_reg;
    assign tx_request_o = tx_request_reg;
    assign tx_cancel_o = tx_cancel_request_reg;
    assign mailbox_irq_o = mailbox_irq_reg;
    assign error_irq_o = error_irq_reg;
endmodule

/* File: design/cmf_pkg.sv */
// Functional notes
// - Mask one serves mailboxes 2-3, mask zero 0-1
// - Mailboxes 3,2 are checked before 1,0
// - Format select clear: mailbox extension bit decides format
// - Format select set: both formats, standard uses 11 bits
// - Mask bit 0 compares, 1 is don't care
// - Direction bits 7-6: 0 transmit, 1 receive
// - Enabled mailbox refuses identifier writes
// - Transmit control layout: ack, abort, request, cancel
// - Request set and cancel written independently
// - Transmit ack: hardware set, write-1 clear, set wins
// - Transmit ack raises masked mailbox flag
// - Abort ack and abort flag, write-1 clear, set wins
// - Pending request sends message and locks mailbox
// - Software sets request, set beats internal clear
// - Remote request sets request of mailbox 2/3
// - Request clears on success or requested abort
// - Write to locked mailbox is dropped, flags denial
// - Software sets cancel, set beats internal clear
// - Cancel withdraws idle request, waits for active end
// - Cancelled end: ack, abort ack or error status
// - Cancel without request clears at once
// - Receive control layout: remote, lost, pending, protect
// - Store sets pending; write-1 clears pending and lost
// - Overwrite of unread message sets lost, unless protected
// - Protected mailbox kept, later mailboxes tried
// - Remote pending flag, clear wins, software clear gated
package cmf_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int ID_W = 29;
    localparam int NUM_MBX = 6;

    localparam logic [15:0] OFF_MAILBOX_DIR_ENABLE_REG = 16'h7100;
    localparam logic [15:0] OFF_TCR = 16'h7101;
    localparam logic [15:0] OFF_RCR = 16'h7102;
    localparam logic [15:0] OFF_MASK0_HI = 16'h7108;
    localparam logic [15:0] OFF_MASK0_LO = 16'h7109;
    localparam logic [15:0] OFF_MASK1_HI = 16'h710A;
    localparam logic [15:0] OFF_MASK1_LO = 16'h710B;
    localparam logic [15:0] OFF_STATUS = 16'h710C;
    localparam logic [15:0] OFF_INT_MASK = 16'h710D;
    // Identifier words: high at base + 2n, low at base + 2n + 1
    localparam logic [15:0] OFF_ID_BASE = 16'h7110;

    localparam logic [15:0] RST_MAILBOX_DIR_ENABLE_REG = 16'h0000;
    localparam logic [15:0] RST_MASK_HI = 16'h0000;
    localparam logic [15:0] RST_MASK_LO = 16'h0000;
    localparam logic [15:0] RST_INT_MASK = 16'h0000;

    localparam int MASK_SEL_BIT = 15;
    localparam int ID_EXT_BIT = 15;
    localparam logic [28:0] STD_ID_BITS = 29'h1FFC_0000;

    localparam int ST_WD_BIT = 0;
    localparam int ST_ABORT_BIT = 1;
    localparam int ST_ERR_BIT = 2;
    localparam int IM_ABORT_BIT = 8;
    localparam int IM_WD_BIT = 9;
    localparam int IM_ERR_BIT = 10;
endpackage

/* File: verification/cmf_engine_model.sv */
`timescale 1ns/10ps
// Sends the highest requested mailbox, four busy cycles an attempt;
// mode_i picks the ending: 0 success, 1 lost arbitration, 2 bus error
module cmf_engine_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Bench control and design requests
    input wire logic [1:0] mode_i,
    input wire logic [3:0] tx_request_i,
    // Engine status
    output logic tx_busy_o,
    output logic [2:0] tx_mbx_o,
    output logic tx_done_o,
    output logic tx_abort_o,
    output logic tx_error_o
);
    logic [2:0] cnt_reg;
    logic [2:0] pick;
    logic last;
    assign pick = tx_request_i[3] ? 3'h5 : tx_request_i[2] ? 3'h4 : tx_request_i[1] ? 3'h3 : 3'h2;
    assign last = tx_busy_o && cnt_reg == 3'h1;
    assign tx_done_o = last && mode_i == 2'h0;
    assign tx_abort_o = last && mode_i == 2'h1;
    assign tx_error_o = last && mode_i == 2'h2;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 3'h0;
            tx_busy_o <= 1'b0;
            tx_mbx_o <= 3'h0;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
            tx_busy_o <= cnt_reg != 3'h1;
            // Between attempts the number is junk, never the last one
            if (cnt_reg == 3'h1) tx_mbx_o <= ~tx_mbx_o;
        end else if (|tx_request_i) begin
            cnt_reg <= 3'h4;
            tx_busy_o <= 1'b1;
            tx_mbx_o <= pick;
        end
    end
endmodule

/* File: verification/cmf_mailbox_ctrl_assertions.sv */
`timescale 1ns/10ps
module cmf_mailbox_ctrl_assertions (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [cmf_pkg::ADDR_W-1:0] addr_i,
    input wire logic [cmf_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_stb_i,
    input wire logic rd_stb_i,
    input wire logic [cmf_pkg::DATA_W-1:0] rdata_o,
    // Engine side
    input wire logic rx_valid_i,
    input wire logic rx_remote_i,
    input wire logic rx_store_o,
    input wire logic [3:0] tx_request_o,
    input wire logic [3:0] tx_cancel_o,
    input wire logic tx_busy_i,
    input wire logic [2:0] tx_mbx_i,
    input wire logic tx_done_i,
    input wire logic tx_abort_i,
    input wire logic tx_error_i
);
    import cmf_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic wr_tcr;
    logic tx_event;
    logic [3:0] ev_bit;
    logic [3:0] lone;
    assign wr_tcr = wr_stb_i && addr_i == OFF_TCR;
    assign tx_event = tx_done_i || tx_abort_i || tx_error_i;
    // Numbers outside 2..5 shift the bit out and select nothing
    assign ev_bit = 4'h1 << (tx_mbx_i - 3'h2);
    assign lone = wr_tcr ? wdata_i[3:0] & ~wdata_i[7:4] & ~tx_request_o : 4'h0;
    a_read_idle: assert property (!$past(rd_stb_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    a_tcr_readback: assert property (rd_stb_i && addr_i == OFF_TCR
        |=> rdata_o[7:0] == $past({tx_request_o, tx_cancel_o}))
        else $error("request bits read wrong");
    a_store_cause: assert property (rx_store_o |-> $past(rx_valid_i))
        else $error("store without frame");
    a_req_source: assert property ((tx_request_o & ~$past(tx_request_o)
        & ~($past(wr_tcr) ? $past(wdata_i[7:4]) : 4'h0)
        & ~($past(rx_valid_i && rx_remote_i) ? 4'h3 : 4'h0)) == 4'h0)
        else $error("request rose without cause");
    a_set_wins: assert property (wr_tcr
        |=> (tx_request_o & $past(wdata_i[7:4])) == $past(wdata_i[7:4]))
        else $error("software request set lost");
    a_done_clears: assert property (tx_done_i && !(wr_tcr && |(wdata_i[7:4] & ev_bit))
        |=> (tx_request_o & $past(ev_bit)) == 4'h0)
        else $error("request kept after success");
    a_cancel_drop: assert property (lone != 4'h0
        |=> (tx_cancel_o & $past(lone)) == 4'h0)
        else $error("cancel without request kept");
    a_cancel_hold: assert property ((tx_cancel_o & ev_bit) != 4'h0 && tx_busy_i
        && !tx_event |=> (tx_cancel_o & $past(ev_bit)) != 4'h0)
        else $error("cancel dropped mid send");
    a_abort_retry: assert property (tx_abort_i && (tx_cancel_o & ev_bit) == 4'h0
        && (tx_request_o & ev_bit) != 4'h0 |=> (tx_request_o & $past(ev_bit)) != 4'h0)
        else $error("request cleared on plain abort");
endmodule

/* File: verification/cmf_mailbox_ctrl_tb.sv */
`timescale 1ns/10ps
module cmf_mailbox_ctrl_tb;
    import cmf_pkg::*;
    localparam logic [28:0] ID_A = 29'h0123_4567;
    localparam logic [28:0] ID_B = 29'h0055_0AA0;
    logic clk_i, rstn_i, wr_stb_i, rd_stb_i, rx_valid_i, rx_ext_i, rx_remote_i;
    logic rx_store_o, tx_busy_i, tx_done_i, tx_abort_i, tx_error_i;
    logic mailbox_irq_o, error_irq_o;
    logic [15:0] addr_i, wdata_i, rdata_o;
    logic [28:0] rx_id_i;
    logic [1:0] rx_store_mbx_o, mode;
    logic [3:0] tx_request_o, tx_cancel_o;
    logic [2:0] tx_mbx_i;
    int fail_count, compares;
    cmf_mailbox_ctrl dut (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_stb_i, .rd_stb_i, .rdata_o,
        .rx_valid_i, .rx_id_i, .rx_ext_i, .rx_remote_i, .rx_store_o, .rx_store_mbx_o,
        .tx_request_o, .tx_cancel_o, .tx_busy_i, .tx_mbx_i, .tx_done_i, .tx_abort_i,
        .tx_error_i, .mailbox_irq_o, .error_irq_o);
    cmf_engine_model engine (.clk_i, .rstn_i, .mode_i(mode), .tx_request_i(tx_request_o),
        .tx_busy_o(tx_busy_i), .tx_mbx_o(tx_mbx_i), .tx_done_o(tx_done_i),
        .tx_abort_o(tx_abort_i), .tx_error_o(tx_error_i));
    task automatic results();
        $display("Compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_stb_i <= 1'b1;
        @(posedge clk_i);
        wr_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdc(input string what, input logic [15:0] a, input logic [15:0] exp);
        addr_i <= a;
        rd_stb_i <= 1'b1;
        @(posedge clk_i);
        rd_stb_i <= 1'b0;
        #1;
        chk(what, rdata_o, exp);
        @(posedge clk_i);
    endtask
    // Mailbox -1 expects a drop, -2 leaves the store unchecked
    task automatic frm(input logic [28:0] id, input logic ext, input logic rem, input int mbx);
        rx_valid_i <= 1'b1;
        rx_id_i <= id;
        rx_ext_i <= ext;
        rx_remote_i <= rem;
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        rx_id_i <= ~id;
        rx_ext_i <= ~ext;
        #1;
        if (mbx > -2) chk("store", {15'h0000, rx_store_o}, {15'h0000, mbx >= 0});
        if (mbx >= 0) chk("store_mbx", {14'h0000, rx_store_mbx_o}, 16'(mbx));
        @(posedge clk_i);
    endtask
    task automatic wait_clear(input logic [3:0] m);
        int n;
        n = 0;
        #1;
        while ((tx_request_o & m) !== 4'h0) begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > 60) begin
                fail_count++;
                $display("[FAIL] request expected 0 seen %h", tx_request_o);
                results();
            end
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        {rstn_i, wr_stb_i, rd_stb_i, rx_valid_i, rx_ext_i, rx_remote_i} = 6'h00;
        {addr_i, wdata_i, rx_id_i, mode} = '0;
        fail_count = 0;
        compares = 0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rdc("mailbox_dir_enable_reg", OFF_MAILBOX_DIR_ENABLE_REG, 16'h0000);
        rdc("tcr", OFF_TCR, 16'h0000);
        rdc("rcr", OFF_RCR, 16'h0000);
        rdc("unmapped", 16'h7150, 16'h0000);
        for (int n = 0; n < 3; n++) begin
            wr(OFF_ID_BASE + 16'(2 * n), {3'h4, ID_A[28:16]});
            wr(OFF_ID_BASE + 16'(2 * n + 1), ID_A[15:0]);
        end
        wr(OFF_ID_BASE + 16'h0006, {3'h4, ID_B[28:16]});
        wr(OFF_ID_BASE + 16'h0007, ID_B[15:0]);
        wr(OFF_MAILBOX_DIR_ENABLE_REG, 16'h0047);
        rdc("mailbox_dir_enable_reg", OFF_MAILBOX_DIR_ENABLE_REG, 16'h0047);
        wr(OFF_ID_BASE, 16'h0000);
        rdc("id0", OFF_ID_BASE, {3'h4, ID_A[28:16]});
        wr(OFF_RCR, 16'h0006);
        frm(ID_A, 1'b1, 1'b0, 2);
        frm(ID_A, 1'b1, 1'b0, 1);
        frm(ID_A, 1'b1, 1'b0, 0);
        frm(ID_A, 1'b1, 1'b0, 0);
        rdc("rcr", OFF_RCR, 16'h0176);
        wr(OFF_RCR, 16'h0056);
        rdc("rcr", OFF_RCR, 16'h0026);
        frm(ID_A, 1'b0, 1'b0, -1);
        frm(ID_A ^ 29'h0000_0001, 1'b1, 1'b0, -1);
        wr(OFF_MASK0_LO, 16'h0001);
        frm(ID_A ^ 29'h0000_0001, 1'b1, 1'b0, 0);
        wr(OFF_MASK0_HI, 16'h8000);
        frm(ID_A | 29'h0003_FFFF, 1'b0, 1'b0, 0);
        wr(OFF_INT_MASK, 16'h0010);
        wr(OFF_MAILBOX_DIR_ENABLE_REG, 16'h0077);
        wr(OFF_TCR, 16'h0040);
        chk("request", {12'h000, tx_request_o}, 16'h0004);
        wait_clear(4'h4);
        rdc("tcr", OFF_TCR, 16'h4000);
        chk("mbx_irq", {15'h0000, mailbox_irq_o}, 16'h0001);
        wr(OFF_TCR, 16'h4000);
        wr(OFF_TCR, 16'h0004);
        rdc("tcr", OFF_TCR, 16'h0000);
        chk("mbx_irq", {15'h0000, mailbox_irq_o}, 16'h0000);
        mode <= 2'h1;
        wr(OFF_TCR, 16'h0080);
        repeat (12) @(posedge clk_i);
        chk("retry", {12'h000, tx_request_o}, 16'h0008);
        wr(OFF_ID_BASE + 16'h000A, 16'h0000);
        rdc("status", OFF_STATUS, 16'h0001);
        wr(OFF_TCR, 16'h0008);
        wait_clear(4'h8);
        rdc("tcr", OFF_TCR, 16'h0800);
        rdc("status", OFF_STATUS, 16'h0003);
        wr(OFF_INT_MASK, 16'h0110);
        #1;
        chk("err_irq", {15'h0000, error_irq_o}, 16'h0001);
        mode <= 2'h0;
        wr(OFF_MAILBOX_DIR_ENABLE_REG, 16'h007F);
        frm(ID_B, 1'b1, 1'b1, -2);
        #1;
        chk("remote", {12'h000, tx_request_o}, 16'h0002);
        wait_clear(4'h2);
        rdc("rcr", OFF_RCR, 16'h0136);
        results();
    end
endmodule
bind cmf_mailbox_ctrl cmf_mailbox_ctrl_assertions chk_u (.clk_i, .rstn_i, .addr_i, .wdata_i,
    .wr_stb_i, .rd_stb_i, .rdata_o, .rx_valid_i, .rx_remote_i, .rx_store_o, .tx_request_o,
    .tx_cancel_o, .tx_busy_i, .tx_mbx_i, .tx_done_i, .tx_abort_i, .tx_error_i);
